// ===== rtl/cmmsf_pkg.sv
package cmmsf_pkg;

    // Data space file addresses (index; byte address is four times this)
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_TIMER    = 7'h01;
    localparam logic [6:0] ADDR_PC_LO    = 7'h02;
    localparam logic [6:0] ADDR_STATUS   = 7'h03;
    localparam logic [6:0] ADDR_PTR      = 7'h04;
    localparam logic [6:0] ADDR_PA       = 7'h05;
    localparam logic [6:0] ADDR_PB       = 7'h06;
    localparam logic [6:0] ADDR_UNIMPL   = 7'h07;
    localparam logic [6:0] ADDR_NVBUF    = 7'h08;
    localparam logic [6:0] ADDR_NVPTR    = 7'h09;
    localparam logic [6:0] ADDR_PC_HI    = 7'h0A;
    localparam logic [6:0] ADDR_NVCTRL   = 7'h50;
    localparam logic [6:0] GPR_FIRST     = 7'h0C;
    localparam logic [6:0] GPR_LAST      = 7'h4F;
    localparam int         GPR_WORDS     = 68;
    localparam int         GPR_AW        = 7;

    // Program memory shape
    localparam int         PC_W          = 13;
    localparam int         INSTR_W       = 14;
    localparam int         PROG_WORDS    = 1024;
    localparam int         PROG_AW       = 10;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;

    // Nonvolatile store shape
    localparam int         NV_BYTES      = 64;
    localparam int         NV_AW         = 6;

    // Field positions
    localparam int         TIMEOUT_BIT   = 4;
    localparam int         PWRDN_BIT     = 3;
    localparam int         NVCTRL_RD_BIT = 0;
    localparam int         NVCTRL_WR_BIT = 1;
    localparam int         PC_HI_W       = 5;
    localparam int         PA_W          = 5;

    // Reset values
    localparam logic [7:0] STATUS_RESET  = 8'h18;
    localparam logic [4:0] PC_HI_RESET   = 5'h00;

    // Access phase cycle at which read data is captured
    localparam logic       APB_CAPTURE   = 1'b1;

endpackage : cmmsf_pkg

// ===== rtl/cmmsf_sync_ram.sv
`timescale 1ns/1ps
module cmmsf_sync_ram #(
    parameter int W  = 8,
    parameter int D  = 64,
    parameter int AW = 6
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [D];
    logic [W-1:0] rdata_q;

    // Array has no reset; contents are whatever was last written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read, one cycle after the address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

    assign rdata = rdata_q;

endmodule : cmmsf_sync_ram

// ===== rtl/cmmsf_core_mem_map.sv
`timescale 1ns/1ps
module cmmsf_core_mem_map #(
    parameter int PADDR_W = 12
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Core events
    input  wire logic               external_master_clear_n,
    input  wire logic               pc_step,
    input  wire logic               irq_accept,
    input  wire logic               wdt_time_out,
    input  wire logic               sleep_entry,
    // Program image load
    input  wire logic               prog_load_en,
    input  wire logic [9:0]         prog_load_addr,
    input  wire logic [13:0]        prog_load_data,
    // Fetch and pin latches
    output logic      [12:0]        instr_addr,
    output logic      [13:0]        instr_word,
    output logic      [4:0]         port_a_pins,
    output logic      [7:0]         port_b_pins
);

    // Storage
    logic [12:0] pc_q;
    logic [12:0] pc_d;
    logic [4:0]  pc_hi_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  ptr_q;
    logic [7:0]  timer_q;
    logic [4:0]  pa_q;
    logic [7:0]  pb_q;
    logic [7:0]  nvbuf_q;
    logic [5:0]  nvptr_q;
    logic        nv_rd_pend_q;
    logic        clr_meta_q;
    logic        clr_sync_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        wait_q;
    logic [31:0] prdata_q;

    // Memory read data
    logic [7:0]  gpr_rdata;
    logic [7:0]  nv_rdata;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Master clear pin crosses in through two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_meta_q <= 1'b1;
            clr_sync_q <= 1'b1;
        end else begin
            clr_meta_q <= external_master_clear_n;
            clr_sync_q <= clr_meta_q;
        end
    end

    wire soft_clr = ~clr_sync_q;

    // Bus phase decode
    wire        access   = psel & penable;
    wire        done     = access & pready_q;
    wire        in_range = (paddr[PADDR_W-1:9] == '0);
    wire [6:0]  file_addr = paddr[8:2];

    // Indirect slot has no storage; pointer supplies the address
    wire [6:0]  eff_addr = (file_addr == cmmsf_pkg::ADDR_INDIRECT) ? ptr_q[6:0] : file_addr;

    // Data space decode: special registers versus general RAM
    wire hit_timer  = in_range & (eff_addr == cmmsf_pkg::ADDR_TIMER);
    wire hit_pc_lo  = in_range & (eff_addr == cmmsf_pkg::ADDR_PC_LO);
    wire hit_status = in_range & (eff_addr == cmmsf_pkg::ADDR_STATUS);
    wire hit_ptr    = in_range & (eff_addr == cmmsf_pkg::ADDR_PTR);
    wire hit_pa     = in_range & (eff_addr == cmmsf_pkg::ADDR_PA);
    wire hit_pb     = in_range & (eff_addr == cmmsf_pkg::ADDR_PB);
    wire hit_nvbuf  = in_range & (eff_addr == cmmsf_pkg::ADDR_NVBUF);
    wire hit_nvptr  = in_range & (eff_addr == cmmsf_pkg::ADDR_NVPTR);
    wire hit_pc_hi  = in_range & (eff_addr == cmmsf_pkg::ADDR_PC_HI);
    wire hit_nvctrl = in_range & (eff_addr == cmmsf_pkg::ADDR_NVCTRL);
    wire hit_gpr    = in_range & (eff_addr >= cmmsf_pkg::GPR_FIRST)
                      & (eff_addr <= cmmsf_pkg::GPR_LAST);
    wire hit_any    = hit_timer | hit_pc_lo | hit_status | hit_ptr | hit_pa | hit_pb
                      | hit_nvbuf | hit_nvptr | hit_pc_hi | hit_nvctrl | hit_gpr;

    wire [6:0] gpr_index = 7'(eff_addr - cmmsf_pkg::GPR_FIRST);

    // Writes land only at the completing edge
    wire wr_done    = done & pwrite;
    wire pc_lo_wr   = wr_done & hit_pc_lo;
    wire nvctrl_wr  = wr_done & hit_nvctrl;
    wire nv_rd      = nvctrl_wr & pwdata[cmmsf_pkg::NVCTRL_RD_BIT];
    wire nv_wr      = nvctrl_wr & pwdata[cmmsf_pkg::NVCTRL_WR_BIT];

    // Read mux; missing bits and empty slots fall to zero
    wire [7:0] rd_mux =
        hit_timer  ? timer_q :
        hit_pc_lo  ? pc_q[7:0] :
        hit_status ? status_q :
        hit_ptr    ? ptr_q :
        hit_pa     ? {3'h0, pa_q} :
        hit_pb     ? pb_q :
        hit_nvbuf  ? nvbuf_q :
        hit_nvptr  ? {2'h0, nvptr_q} :
        hit_pc_hi  ? {3'h0, pc_hi_q} :
        hit_nvctrl ? {7'h00, nv_rd_pend_q} :
        hit_gpr    ? gpr_rdata : 8'h00;

    // Access phase: one cycle for RAM read, one to capture, then ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            wait_q    <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else if (done) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            wait_q    <= 1'b0;
        end else if (access) begin
            if (wait_q == cmmsf_pkg::APB_CAPTURE) begin
                pready_q  <= 1'b1;
                pslverr_q <= ~in_range;
                prdata_q  <= pwrite ? 32'h00000000 : {24'h000000, rd_mux};
            end else begin
                wait_q <= 1'b1;
            end
        end
    end

    // Program counter next value; clear beats vector beats load beats step
    assign pc_d = soft_clr   ? cmmsf_pkg::RESET_VECTOR :
                  irq_accept ? cmmsf_pkg::IRQ_VECTOR :
                  pc_lo_wr   ? {pc_hi_q, pwdata[7:0]} :
                  pc_step    ? pc_q + 13'h0001 :
                  pc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= cmmsf_pkg::RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
        end
    end

    // Holding register only ever loaded by software, never from the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_hi_q <= cmmsf_pkg::PC_HI_RESET;
        end else if (soft_clr) begin
            pc_hi_q <= cmmsf_pkg::PC_HI_RESET;
        end else if (wr_done & hit_pc_hi) begin
            pc_hi_q <= pwdata[4:0];
        end
    end

    // Flag bits follow hardware only; software writes skip them
    always_comb begin
        status_d = status_q;
        if (wr_done & hit_status) begin
            status_d = {pwdata[7:5], status_q[4:3], pwdata[2:0]};
        end
        if (soft_clr) begin
            status_d[7:5] = 3'h0;
        end
        if (wdt_time_out) begin
            status_d[cmmsf_pkg::TIMEOUT_BIT] = 1'b0;
        end
        if (sleep_entry) begin
            status_d[cmmsf_pkg::PWRDN_BIT] = 1'b0;
        end
    end

    // Power-on only sets the flags; master clear keeps them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= cmmsf_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Plain static registers shared by core and peripherals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q   <= 8'h00;
            timer_q <= 8'h00;
            pa_q    <= 5'h00;
            pb_q    <= 8'h00;
        end else begin
            if (wr_done & hit_ptr) begin
                ptr_q <= pwdata[7:0];
            end
            if (wr_done & hit_timer) begin
                timer_q <= pwdata[7:0];
            end
            if (wr_done & hit_pa) begin
                pa_q <= pwdata[4:0];
            end
            if (wr_done & hit_pb) begin
                pb_q <= pwdata[7:0];
            end
        end
    end

    // Nonvolatile pointer and buffer; read data lands a cycle after request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvptr_q      <= 6'h00;
            nvbuf_q      <= 8'h00;
            nv_rd_pend_q <= 1'b0;
        end else begin
            nv_rd_pend_q <= nv_rd;
            if (wr_done & hit_nvptr) begin
                nvptr_q <= pwdata[5:0];
            end
            if (nv_rd_pend_q) begin
                nvbuf_q <= nv_rdata;
            end else if (wr_done & hit_nvbuf) begin
                nvbuf_q <= pwdata[7:0];
            end
        end
    end

    // General purpose RAM behind the data path
    cmmsf_sync_ram #(
        .W  (8),
        .D  (cmmsf_pkg::GPR_WORDS),
        .AW (cmmsf_pkg::GPR_AW)
    ) u_gpr (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (wr_done & hit_gpr),
        .waddr (gpr_index),
        .wdata (pwdata[7:0]),
        .raddr (gpr_index),
        .rdata (gpr_rdata)
    );

    // Nonvolatile store, addressed only by the pointer
    cmmsf_sync_ram #(
        .W  (8),
        .D  (cmmsf_pkg::NV_BYTES),
        .AW (cmmsf_pkg::NV_AW)
    ) u_nv (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (nv_wr),
        .waddr (nvptr_q),
        .wdata (nvbuf_q),
        .raddr (nvptr_q),
        .rdata (nv_rdata)
    );

    // Program array on its own port, so fetch never waits on data traffic
    cmmsf_sync_ram #(
        .W  (cmmsf_pkg::INSTR_W),
        .D  (cmmsf_pkg::PROG_WORDS),
        .AW (cmmsf_pkg::PROG_AW)
    ) u_prog (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (prog_load_en),
        .waddr (prog_load_addr),
        .wdata (prog_load_data),
        .raddr (pc_q[9:0]),
        .rdata (instr_word)
    );

    // Outputs straight from flops
    assign instr_addr  = pc_q;
    assign port_a_pins = pa_q;
    assign port_b_pins = pb_q;
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;

    // Clear forces the reset vector
    vector_reset_a: assert property (
        soft_clr |=> (pc_q == cmmsf_pkg::RESET_VECTOR))
        else $error("counter not at reset vector after clear");

    // Accepted interrupt jumps to its vector
    vector_irq_a: assert property (
        (irq_accept && !soft_clr) |=> (pc_q == cmmsf_pkg::IRQ_VECTOR))
        else $error("counter not at interrupt vector");

    // Low byte write joins the holding bits
    pc_lo_load_a: assert property (
        (pc_lo_wr && !soft_clr && !irq_accept)
        |=> (pc_q == {$past(pc_hi_q), $past(pwdata[7:0])}))
        else $error("counter load did not use holding bits");

    // Holding bits never pick up counter changes
    holding_only_a: assert property (
        (!(wr_done && hit_pc_hi) && !soft_clr) |=> $stable(pc_hi_q))
        else $error("holding register changed without a write");

    // Step wraps across the full counter width
    pc_step_a: assert property (
        (pc_step && !soft_clr && !irq_accept && !pc_lo_wr)
        |=> (pc_q == $past(pc_q) + 13'h0001))
        else $error("counter step wrong");

    // Flags hold through master clear
    flags_keep_a: assert property (
        (soft_clr && !wdt_time_out && !sleep_entry) |=> $stable(status_q[4:3]))
        else $error("flags lost on master clear");

    // Empty slots answer zero
    unimpl_zero_a: assert property (
        (done && !pwrite && !hit_any) |-> (prdata_q == 32'h00000000))
        else $error("unimplemented location read nonzero");

    // Upper data bits always zero
    upper_zero_a: assert property (
        pready_q |-> (prdata_q[31:8] == 24'h000000))
        else $error("upper read bits nonzero");

    // Pointer read loads the buffer from the store
    nv_load_a: assert property (
        nv_rd |=> ##1 (nvbuf_q == $past(nv_rdata)))
        else $error("buffer not loaded from store");

    // Ready two cycles into the access phase
    ready_delay_a: assert property (
        (access && !pready_q && !wait_q) |-> ##2 pready_q)
        else $error("ready late");

endmodule : cmmsf_core_mem_map

// ===== test/cmmsf_core_model.sv
`timescale 1ns/1ps
module cmmsf_core_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench requests: step, interrupt, time-out, sleep
    input  wire logic [3:0]  req,
    // Core events
    output logic             pc_step,
    output logic             irq_accept,
    output logic             wdt_time_out,
    output logic             sleep_entry,
    // Program image load
    output logic             prog_load_en,
    output logic [9:0]       prog_load_addr,
    output logic [13:0]      prog_load_data,
    output logic             load_done
);
    logic [3:0]  req_q;
    logic [10:0] cnt_q;

    // Levels from the bench become one-cycle pulses, as the core issues them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 4'h0;
            {pc_step, irq_accept, wdt_time_out, sleep_entry} <= 4'h0;
        end else begin
            req_q <= req;
            {pc_step, irq_accept, wdt_time_out, sleep_entry} <= req & ~req_q;
        end
    end

    // Image load walks the whole array once after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 11'h000;
        end else if (!cnt_q[10]) begin
            cnt_q <= cnt_q + 11'h001;
        end
    end

    // Word holds its own address, so aliasing shows directly
    assign load_done      = cnt_q[10];
    assign prog_load_en   = !cnt_q[10];
    assign prog_load_addr = cnt_q[9:0];
    assign prog_load_data = {4'h5, cnt_q[9:0]};
endmodule : cmmsf_core_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clear_n;
    logic [3:0]  req;
    logic        pc_step;
    logic        irq_accept;
    logic        wdt_time_out;
    logic        sleep_entry;
    logic        ld_en;
    logic [9:0]  ld_addr;
    logic [13:0] ld_data;
    logic        ld_done;
    logic [12:0] instr_addr;
    logic [13:0] instr_word;
    logic [4:0]  pa;
    logic [7:0]  pb;
    logic [31:0] rd;
    logic        err;
    int          errors;
    int          num_checks;
    int          cyc;
    // Rows: file index, write value, value read back
    logic [23:0] rows [13] = '{24'h04_20_20, 24'h20_5A_5A, 24'h00_77_77, 24'h07_FF_00, 24'h05_FF_1F,
                               24'h03_E7_FF, 24'h0A_FF_1F, 24'h09_FF_3F, 24'h01_C3_C3, 24'h06_A5_A5,
                               24'h4F_3C_3C, 24'h0B_FF_00, 24'h0C_96_96};

    cmmsf_core_mem_map DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_master_clear_n(ext_clear_n), .pc_step(pc_step),
        .irq_accept(irq_accept), .wdt_time_out(wdt_time_out), .sleep_entry(sleep_entry),
        .prog_load_en(ld_en), .prog_load_addr(ld_addr), .prog_load_data(ld_data),
        .instr_addr(instr_addr), .instr_word(instr_word), .port_a_pins(pa), .port_b_pins(pb));

    cmmsf_core_model u_core (.pclk(pclk), .presetn(presetn), .req(req), .pc_step(pc_step),
        .irq_accept(irq_accept), .wdt_time_out(wdt_time_out), .sleep_entry(sleep_entry),
        .prog_load_en(ld_en), .prog_load_addr(ld_addr), .prog_load_data(ld_data),
        .load_done(ld_done));

    // Clock
    always #12.5 pclk = ~pclk;

    // Hang guard, far above the roughly 1400 cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Request held until pready is sampled high; only the hang guard ends a wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [6:0] i, input logic [7:0] d);
        apb(1'b1, {3'h0, i, 2'h0}, d);
    endtask : wreg

    task automatic rchk(input logic [6:0] i, input logic [7:0] e, input string m);
        apb(1'b0, {3'h0, i, 2'h0}, 8'h00);
        chk(rd, {24'h000000, e}, m);
    endtask : rchk

    task automatic pulse(input int b);
        @(posedge pclk);
        req[b] <= 1'b1;
        @(posedge pclk);
        req[b] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h00000000;
        ext_clear_n = 1'b1;
        req = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(instr_addr), 32'h00000000, "pc reset");
        rchk(7'h03, cmmsf_pkg::STATUS_RESET, "status reset");
        rchk(7'h0A, 8'h00, "holding reset");
        while (ld_done !== 1'b1) @(posedge pclk);
        for (int r = 0; r < 13; r++) begin
            wreg(rows[r][22:16], rows[r][15:8]);
            rchk(rows[r][22:16], rows[r][7:0], "row");
        end
        rchk(7'h20, 8'h77, "indirect write");
        chk({19'h00000, pa, pb}, 32'h00001FA5, "pins");
        // Out of range: error flagged, write dropped, read zero
        apb(1'b1, 12'h230, 8'h55);
        chk(32'(err), 32'h00000001, "slverr wr");
        apb(1'b0, 12'h230, 8'h00);
        chk({rd[30:0], err}, 32'h00000001, "slverr rd");
        // Nonvolatile store through pointer, top and bottom bytes
        wreg(7'h08, 8'h96);
        wreg(cmmsf_pkg::ADDR_NVCTRL, 8'h02);
        wreg(7'h09, 8'h00);
        wreg(7'h08, 8'h11);
        wreg(cmmsf_pkg::ADDR_NVCTRL, 8'h02);
        wreg(7'h09, 8'h3F);
        wreg(cmmsf_pkg::ADDR_NVCTRL, 8'h01);
        repeat (3) @(posedge pclk);
        rchk(7'h08, 8'h96, "nv top");
        wreg(7'h09, 8'h00);
        wreg(cmmsf_pkg::ADDR_NVCTRL, 8'h01);
        repeat (3) @(posedge pclk);
        rchk(7'h08, 8'h11, "nv bottom");
        // Every 400h alias of 020h fetches the same word
        for (int k = 0; k < 8; k++) begin
            wreg(7'h0A, 8'(k * 4));
            wreg(7'h02, 8'h20);
            repeat (3) @(posedge pclk);
            chk(32'(instr_addr), 32'(k * 1024 + 32), "pc load");
            chk(32'(instr_word), 32'h00001420, "alias");
        end
        // Step past 1FFFh; holding keeps its value
        wreg(7'h0A, 8'h1F);
        wreg(7'h02, 8'hFF);
        pulse(3);
        chk(32'(instr_addr), 32'h00000000, "pc wrap");
        rchk(7'h0A, 8'h1F, "no copy back");
        rchk(7'h02, 8'h00, "pc low");
        pulse(2);
        chk({3'h0, instr_addr, 2'h0, instr_word}, 32'h00041404, "irq vector");
        // Master clear keeps flags, clears bank bits and counter
        @(posedge pclk);
        ext_clear_n <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(32'(instr_addr), 32'h00000000, "clear pc");
        ext_clear_n <= 1'b1;
        repeat (3) @(posedge pclk);
        rchk(7'h03, 8'h1F, "flags kept");
        rchk(7'h0A, 8'h00, "holding clear");
        pulse(1);
        rchk(7'h03, 8'h0F, "time-out clr");
        pulse(0);
        rchk(7'h03, 8'h07, "sleep clr");
        // Second power-on reset in mid-run, counter moved off zero first
        pulse(3);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(instr_addr), 32'h00000000, "pc reset again");
        chk({19'h00000, pa, pb}, 32'h00000000, "pins reset");
        rchk(7'h03, cmmsf_pkg::STATUS_RESET, "status again");
        report_and_stop();
    end
endmodule : tb_top
